// ==== shared/pwcd_consts.vh ====
// constants for the potentiometer wiper command decoder
`ifndef PWCD_CONSTS_VH
`define PWCD_CONSTS_VH

// command word layout
`define PWCD_WORD_BITS     16
`define PWCD_CTRL_HI       15
`define PWCD_CTRL_LO       12
`define PWCD_ADDR_HI       11
`define PWCD_ADDR_LO       8
`define PWCD_DATA_HI       7
`define PWCD_DATA_LO       0

// control codes
`define PWCD_OP_NOP        4'h0
`define PWCD_OP_WR_WIPER   4'h1
`define PWCD_OP_WR_PRELOAD 4'h2
`define PWCD_OP_READ       4'h3
`define PWCD_OP_COPY       4'h7
`define PWCD_OP_WR_NV      4'h8
`define PWCD_OP_SW_RESET   4'hB
`define PWCD_OP_SHUTDOWN   4'hC

// readback source select in data bits 1..0
`define PWCD_RD_NV         2'h1
`define PWCD_RD_WIPER      2'h3

// reset values
`define PWCD_NV_RESET      8'h80
`define PWCD_PRELOAD_RESET 8'h00

// frame length checks, in falling clock edges
`define PWCD_FRAME_UNIT    8
`define PWCD_FRAME_MIN     16
`define PWCD_FRAME_MAX     32

// timing
`define PWCD_STORE_TIME_US 18000
`define PWCD_CLK_KHZ       20000

`endif

// ==== verilog/pwcd_sync.v ====
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pwcd_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_reset,
  // asynchronous pins in, synchronous levels out
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // pwcd_sync

// ==== verilog/pwcd_top.v ====
// command decoder for a single-channel nonvolatile digital potentiometer
`timescale 1ns/1ps
`include "pwcd_consts.vh"
module pwcd_top #(
  parameter POS128       = 0,
  parameter CNT_W        = 19,
  parameter STORE_CYCLES = `PWCD_STORE_TIME_US * `PWCD_CLK_KHZ / 1000
) (
  // clock and reset
  input  wire        I_CLK,
  input  wire        I_RESET,
  // serial link pins
  input  wire        I_SCLK,
  input  wire        I_SYNC_N,
  input  wire        I_SDI,
  output wire        O_SDO_OUT,
  output wire        O_SDO_OE,
  // control pins
  input  wire        I_INTERFACE_SELECT,
  input  wire        I_WIPER_LOAD_N,
  input  wire        I_HW_RESET_N,
  // word from the two-wire front end
  input  wire        I_I2C_WORD_STB,
  input  wire [15:0] I_I2C_WORD,
  output wire        O_I2C_ACK_EN,
  // state
  output wire [7:0]  O_WIPER,
  output wire [7:0]  O_PRELOAD,
  output wire [7:0]  O_NV_VALUE,
  output wire        O_SHUTDOWN,
  output wire        O_BUSY,
  output wire [7:0]  O_READ_DATA,
  output wire        O_READ_VALID,
  output wire        O_FRAME_DROP
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire [4:0] pins_sync;

  pwcd_sync #(
    .WIDTH (5),
    .INIT  (5'h1E)
  ) u_sync (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_async ({I_HW_RESET_N, I_WIPER_LOAD_N, I_SYNC_N, I_INTERFACE_SELECT, I_SCLK}),
    .o_sync  (pins_sync)
  );

  wire sclk_s     = pins_sync[0];
  wire if_sel_s   = pins_sync[1];
  wire sync_n_s   = pins_sync[2];
  wire load_n_s   = pins_sync[3];
  wire hw_reset_s = ~pins_sync[4];

  reg  sdi_meta_q;
  reg  sdi_q;
  reg  sclk_prev_q;
  reg  sync_prev_q;

  always @(posedge I_CLK) begin
    if (I_RESET) begin
      sdi_meta_q  <= 1'b0;
      sdi_q       <= 1'b0;
      sclk_prev_q <= 1'b0;
      sync_prev_q <= 1'b1;
    end else begin
      sdi_meta_q  <= I_SDI;
      sdi_q       <= sdi_meta_q;
      sclk_prev_q <= sclk_s;
      sync_prev_q <= sync_n_s;
    end
  end

  // edges seen on the system clock; link clock must stay well below 10 MHz
  wire sclk_fall  = sclk_prev_q & ~sclk_s;
  wire sclk_rise  = ~sclk_prev_q & sclk_s;
  wire frame_open = sync_prev_q & ~sync_n_s;
  wire frame_end  = ~sync_prev_q & sync_n_s;
  wire spi_mode   = ~if_sel_s;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [7:0] pwcd_data;
    input [7:0] raw;
    begin
      if (POS128 != 0)
        pwcd_data = {raw[7:1], 1'b0};
      else
        pwcd_data = raw;
    end
  endfunction

  function pwcd_frame_ok;
    input [5:0] cnt;
    begin
      pwcd_frame_ok = (cnt[2:0] == 3'h0) && (cnt >= 6'd`PWCD_FRAME_MIN) && (cnt <= 6'd`PWCD_FRAME_MAX);
    end
  endfunction

  localparam integer     STORE_LAST_I = STORE_CYCLES - 1;
  localparam [CNT_W-1:0] STORE_LAST   = STORE_LAST_I[CNT_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // registers

  reg [15:0]      shift_q;
  reg [5:0]       edge_cnt_q;
  reg             sdo_bit_q;
  reg             sdo_oe_q;
  reg [7:0]       wiper_q;
  reg [7:0]       preload_q;
  reg [7:0]       nv_q;
  reg             shutdown_q;
  reg             busy_q;
  reg [CNT_W-1:0] store_cnt_q;
  reg [7:0]       read_data_q;
  reg             read_valid_q;
  reg             frame_drop_q;
  reg             ack_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // command source select

  wire        spi_done  = spi_mode & frame_end & pwcd_frame_ok(edge_cnt_q);
  wire        i2c_done  = ~spi_mode & I_I2C_WORD_STB;
  wire        exec_stb  = (spi_done | i2c_done) & ~busy_q;
  wire [15:0] exec_word = spi_mode ? shift_q : I_I2C_WORD;

  wire [3:0]  op   = exec_word[`PWCD_CTRL_HI:`PWCD_CTRL_LO];
  wire [3:0]  addr = exec_word[`PWCD_ADDR_HI:`PWCD_ADDR_LO];
  wire [7:0]  data = exec_word[`PWCD_DATA_HI:`PWCD_DATA_LO];
  wire [7:0]  dval = pwcd_data(data);

  reg         do_wr_wiper;
  reg         do_wr_pre;
  reg         do_read;
  reg         do_store;
  reg         do_recall;
  reg         do_wr_nv;
  reg         do_sw_reset;
  reg         do_shdn;

  always @* begin
    do_wr_wiper = 1'b0;
    do_wr_pre   = 1'b0;
    do_read     = 1'b0;
    do_store    = 1'b0;
    do_recall   = 1'b0;
    do_wr_nv    = 1'b0;
    do_sw_reset = 1'b0;
    do_shdn     = 1'b0;
    if (exec_stb) begin
      case (op)
        `PWCD_OP_NOP:        do_wr_wiper = 1'b0;
        `PWCD_OP_WR_WIPER:   do_wr_wiper = (addr == 4'h0);
        `PWCD_OP_WR_PRELOAD: do_wr_pre   = (addr == 4'h0);
        `PWCD_OP_READ:       do_read     = (addr[2:0] == 3'h0) &&
                                           (data[1:0] == `PWCD_RD_NV || data[1:0] == `PWCD_RD_WIPER);
        `PWCD_OP_COPY: begin
          do_store  = (addr[1:0] == 2'h0) & data[0];
          do_recall = (addr[1:0] == 2'h0) & ~data[0];
        end
        `PWCD_OP_WR_NV:      do_wr_nv    = (addr == 4'h0);
        `PWCD_OP_SW_RESET:   do_sw_reset = 1'b1;
        `PWCD_OP_SHUTDOWN:   do_shdn     = (addr == 4'h0);
        default:             do_wr_wiper = 1'b0;
      endcase
    end
  end

  wire [7:0] rd_val = (data[1:0] == `PWCD_RD_NV) ? pwcd_data(nv_q) : pwcd_data(wiper_q);

  ////////////////////////////////////////////////////////////////////////////
  // serial shift, frame count and readback output

  always @(posedge I_CLK) begin
    if (I_RESET) begin
      shift_q      <= 16'h0000;
      edge_cnt_q   <= 6'h00;
      sdo_bit_q    <= 1'b1;
      sdo_oe_q     <= 1'b0;
      frame_drop_q <= 1'b0;
    end else begin
      frame_drop_q <= spi_mode & frame_end & ~pwcd_frame_ok(edge_cnt_q);
      if (~spi_mode || sync_n_s) begin
        // counter clears once the frame is over
        edge_cnt_q <= 6'h00;
        sdo_oe_q   <= 1'b0;
      end else begin
        if (sclk_fall) begin
          // older bits fall out the top, which also serves a daisy chain
          shift_q <= {shift_q[14:0], sdi_q};
          if (edge_cnt_q != 6'h3F)
            edge_cnt_q <= edge_cnt_q + 6'h01;
        end
        if (sclk_rise || frame_open) begin
          sdo_bit_q <= shift_q[15];
          sdo_oe_q  <= ~shift_q[15];
        end
      end
      if (spi_mode && do_read)
        shift_q <= {8'h00, rd_val};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wiper, preload, nonvolatile copy and store lock

  always @(posedge I_CLK) begin
    if (I_RESET) begin
      nv_q         <= `PWCD_NV_RESET;
      wiper_q      <= `PWCD_NV_RESET;
      preload_q    <= `PWCD_PRELOAD_RESET;
      shutdown_q   <= 1'b0;
      busy_q       <= 1'b0;
      store_cnt_q  <= {CNT_W{1'b0}};
      read_data_q  <= 8'h00;
      read_valid_q <= 1'b0;
      ack_en_q     <= 1'b1;
    end else begin
      read_valid_q <= do_read;
      if (do_read)
        read_data_q <= rd_val;
      // store timer; no command is taken while it runs
      if (busy_q) begin
        if (store_cnt_q == {CNT_W{1'b0}})
          busy_q <= 1'b0;
        else
          store_cnt_q <= store_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (do_store || do_wr_nv) begin
        busy_q      <= 1'b1;
        store_cnt_q <= STORE_LAST;
        nv_q        <= do_store ? pwcd_data(wiper_q) : dval;
      end
      ack_en_q <= ~(busy_q | do_store | do_wr_nv);
      if (do_wr_pre)
        preload_q <= dval;
      if (do_shdn)
        shutdown_q <= data[0];
      if (do_sw_reset)
        shutdown_q <= 1'b0;
      // pins take precedence over a command landing in the same cycle
      if (hw_reset_s)
        wiper_q <= pwcd_data(nv_q);
      else if (~load_n_s)
        wiper_q <= preload_q;
      else if (do_wr_wiper)
        wiper_q <= dval;
      else if (do_recall || do_sw_reset)
        wiper_q <= pwcd_data(nv_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign O_SDO_OUT    = 1'b0 & sdo_bit_q;
  assign O_SDO_OE     = sdo_oe_q;
  assign O_I2C_ACK_EN = ack_en_q;
  assign O_WIPER      = wiper_q;
  assign O_PRELOAD    = preload_q;
  assign O_NV_VALUE   = nv_q;
  assign O_SHUTDOWN   = shutdown_q;
  assign O_BUSY       = busy_q;
  assign O_READ_DATA  = read_data_q;
  assign O_READ_VALID = read_valid_q;
  assign O_FRAME_DROP = frame_drop_q;

endmodule // pwcd_top

// ==== bench/pwcd_host.sv ====
// host-side serial link model for the command decoder
`timescale 1ns/1ps
module pwcd_host (
  // link pins
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_sdi,
  input  wire  i_sdo_oe
);
  logic [31:0] rd_q;
  initial begin
    o_sclk = 1'b0;
    o_sync_n = 1'b1;
    o_sdi = 1'b0;
    rd_q = 32'h0;
  end
  // clock idles low between frames; sdo read from the pulled-up line
  task automatic send(input logic [31:0] w, input int n);
    o_sync_n = 1'b0;
    #400;
    for (int i = n - 1; i >= 0; i--) begin
      // data moves on the rise so it stands across the sampling fall
      #200 o_sclk = 1'b1;
      o_sdi = w[i];
      #200 o_sclk = 1'b0;
      rd_q = {rd_q[30:0], ~i_sdo_oe};
    end
    #200 o_sync_n = 1'b1;
    o_sdi = ~o_sdi;
    #1200;
  endtask
endmodule // pwcd_host

// ==== bench/pwcd_chk_sva.sv ====
// port assertions for the command decoder
`timescale 1ns/1ps
module pwcd_chk #(
  parameter STORE_CYCLES = 20
) (
  // clock, reset, pins
  input wire        I_CLK,
  input wire        I_RESET,
  input wire        I_INTERFACE_SELECT,
  input wire        I_WIPER_LOAD_N,
  input wire        I_HW_RESET_N,
  input wire        I_I2C_WORD_STB,
  input wire [15:0] I_I2C_WORD,
  // state
  input wire [7:0]  O_WIPER,
  input wire [7:0]  O_PRELOAD,
  input wire [7:0]  O_NV_VALUE,
  input wire [7:0]  O_READ_DATA,
  input wire        O_READ_VALID,
  input wire        O_BUSY,
  input wire        O_I2C_ACK_EN
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  wire [15:0] w = I_I2C_WORD;
  wire go = I_I2C_WORD_STB && I_INTERFACE_SELECT && !O_BUSY;
  int unsigned busy_cnt_q;
  always @(posedge I_CLK) busy_cnt_q <= (I_RESET || !O_BUSY) ? 0 : busy_cnt_q + 1;
  property p_wr; go && w[15:8] == 8'h10 |=> O_WIPER == $past(w[7:0]); endproperty
  a_wr: assert property (p_wr) else $error("wiper write");
  property p_pre; go && w[15:8] == 8'h20 |=> O_PRELOAD == $past(w[7:0]) && $stable(O_WIPER); endproperty
  a_pre: assert property (p_pre) else $error("preload write");
  property p_nop; go && (w[15:12] == 4'h0 || w[15:12] == 4'hF) |=> $stable({O_WIPER, O_PRELOAD, O_NV_VALUE}); endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state");
  property p_st; go && w[15:12] == 4'h7 && w[9:8] == 2'h0 && w[0] |=> O_BUSY && !O_I2C_ACK_EN && O_NV_VALUE == $past(O_WIPER); endproperty
  a_st: assert property (p_st) else $error("store");
  property p_len; $fell(O_BUSY) |-> busy_cnt_q == STORE_CYCLES; endproperty
  a_len: assert property (p_len) else $error("lock length");
  property p_rd; go && w == 16'h3003 |=> O_READ_VALID && O_READ_DATA == $past(O_WIPER); endproperty
  a_rd: assert property (p_rd) else $error("readback");
  property p_hw; (!I_HW_RESET_N) [*4] |-> O_WIPER == O_NV_VALUE; endproperty
  a_hw: assert property (p_hw) else $error("reset pin");
  property p_ld; (!I_WIPER_LOAD_N && I_HW_RESET_N) [*4] |-> O_WIPER == O_PRELOAD; endproperty
  a_ld: assert property (p_ld) else $error("load pin");
endmodule // pwcd_chk
bind pwcd_top pwcd_chk #(.STORE_CYCLES(STORE_CYCLES)) i_pwcd_chk (.I_CLK(I_CLK), .I_RESET(I_RESET),
  .I_INTERFACE_SELECT(I_INTERFACE_SELECT), .I_WIPER_LOAD_N(I_WIPER_LOAD_N), .I_HW_RESET_N(I_HW_RESET_N),
  .I_I2C_WORD_STB(I_I2C_WORD_STB), .I_I2C_WORD(I_I2C_WORD), .O_WIPER(O_WIPER), .O_PRELOAD(O_PRELOAD),
  .O_NV_VALUE(O_NV_VALUE), .O_READ_DATA(O_READ_DATA), .O_READ_VALID(O_READ_VALID), .O_BUSY(O_BUSY),
  .O_I2C_ACK_EN(O_I2C_ACK_EN));

// ==== bench/testbench.sv ====
// self-checking bench for the command decoder
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sel = 1'b0;
  logic        ld_n = 1'b1;
  logic        hw_n = 1'b1;
  logic        stb = 1'b0;
  logic [15:0] word = 16'h0000;
  wire         sclk, sync_n, sdi, oe, ack, shdn, busy, rv, drop, sdo;
  wire  [7:0]  wip, pre, nv, rdat;
  int          failures = 0;
  int          checked = 0;
  int          drops = 0;
  int          reads = 0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    drops <= drops + drop;
    reads <= reads + rv;
  end
  pwcd_top #(.POS128(0), .STORE_CYCLES(20)) i_pwcd_top (.I_CLK(clk), .I_RESET(rst), .I_SCLK(sclk),
    .I_SYNC_N(sync_n), .I_SDI(sdi), .O_SDO_OUT(sdo), .O_SDO_OE(oe), .I_INTERFACE_SELECT(sel),
    .I_WIPER_LOAD_N(ld_n), .I_HW_RESET_N(hw_n), .I_I2C_WORD_STB(stb), .I_I2C_WORD(word),
    .O_I2C_ACK_EN(ack), .O_WIPER(wip), .O_PRELOAD(pre), .O_NV_VALUE(nv), .O_SHUTDOWN(shdn),
    .O_BUSY(busy), .O_READ_DATA(rdat), .O_READ_VALID(rv), .O_FRAME_DROP(drop));
  pwcd_host i_pwcd_host (.o_sclk(sclk), .o_sync_n(sync_n), .o_sdi(sdi), .i_sdo_oe(oe));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic spi(input logic [31:0] w, input int n);
    i_pwcd_host.send(w, n);
    repeat (4) @(negedge clk);
  endtask
  task automatic iw(input logic [15:0] w);
    @(negedge clk);
    stb = 1'b1;
    word = w;
    @(negedge clk);
    stb = 1'b0;
    @(negedge clk);
  endtask
  task automatic idle;
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
    check("idle", 1'h0, busy);
  endtask
  task automatic pin(input bit hw);
    if (hw) hw_n = 1'b0; else ld_n = 1'b0;
    repeat (4) @(negedge clk);
    hw_n = 1'b1;
    ld_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check("reset", {8'h80, 8'h00, 8'h80, 3'h1}, {wip, pre, nv, shdn, busy, ack});
  endtask
  task automatic t_spi;
    int d;
    spi(32'h105A, 16);
    check("wiper", 8'h5A, wip);
    d = drops;
    spi(32'h1033, 8);
    check("drop", {d + 1, 8'h5A}, {drops, wip});
    spi(32'hFF1077, 24);
    check("wiper24", 8'h77, wip);
    spi(32'h3003, 16);
    spi(32'h0000, 16);
    check("rd wiper", 16'h0077, i_pwcd_host.rd_q[15:0]);
    spi(32'h3001, 16);
    spi(32'h0000, 16);
    check("rd nv", {16'h0080, 8'd2}, {i_pwcd_host.rd_q[15:0], reads[7:0]});
    check("sdo low", 1'h0, sdo);
  endtask
  task automatic t_pre;
    logic [15:0] c[4] = '{16'h0FFF, 16'hF123, 16'h1100, 16'h5012};
    spi(32'h20C3, 16);
    check("preload", {8'hC3, 8'h77}, {pre, wip});
    pin(0);
    check("load", 8'hC3, wip);
    foreach (c[i]) begin
      spi(c[i], 16);
      check("nop", {8'hC3, 8'hC3, 8'h80}, {wip, pre, nv});
    end
  endtask
  task automatic t_store;
    sel = 1'b1;
    repeat (4) @(negedge clk);
    iw(16'h1044);
    iw(16'h7001);
    check("store", {3'h2, 8'h44}, {busy, ack, nv});
    iw(16'h1011);
    check("locked", 8'h44, wip);
    idle;
    iw(16'h1022);
    iw(16'h7000);
    check("recall", 8'h44, wip);
    iw(16'h8099);
    check("nv write", {1'h1, 8'h99}, {busy, nv});
    idle;
    iw(16'h3003);
    check("rd i2c", 8'h44, rdat);
  endtask
  task automatic t_misc;
    iw(16'h2055);
    check("preload i2c", {8'h55, 8'h44}, {pre, wip});
    iw(16'h0F0F);
    iw(16'hF0F0);
    check("nop i2c", {8'h55, 8'h44, 8'h99}, {pre, wip, nv});
    iw(16'hC001);
    check("shdn on", 1'h1, shdn);
    iw(16'hC000);
    check("shdn off", 1'h0, shdn);
    iw(16'hC001);
    iw(16'hB000);
    check("sw reset", {8'h99, 1'h0}, {wip, shdn});
    iw(16'h1012);
    pin(1);
    check("hw reset", 8'h99, wip);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset;
    t_spi;
    t_pre;
    t_store;
    t_misc;
    finish_test;
  end
  initial begin
    #2000000;
    failures++;
    finish_test;
  end
endmodule // testbench
